// >>> verilog/ufc_pkg.sv
// What this block does
// R1 - break request holds line low; software two frames
// R2 - busy until fifo empty and stops sent
// R3 - receive available flag while fifo nonempty
// R4 - each read pops one received character
// R5 - each write pushes; full reported, software obeys
// R6 - baud reference selects system clock or oscillator
// R7 - software reprograms divisor after reference change
// R8 - baud divisor readable for true rate
// R9 - one frame setting for both directions
// R10 - one or two stop bits, both directions
// R11 - parity none, even, odd, one, zero
// R12 - disable finishes current character, flushes fifo
// R13 - infrared mode changes only while disabled
// R14 - character lengths five through eight bits
// R15 - rates from zero to reference over sixteen
// R16 - sixteen-times oversampling, sampled at bit centre
// R17 - idle high, low start bit, lsb first
package ufc_pkg;

    localparam int unsigned DATA_W        = 8;
    localparam int unsigned DIV_W         = 16;
    localparam int unsigned TX_DEPTH      = 16;
    localparam int unsigned RX_DEPTH      = 16;
    localparam int unsigned SYS_CLK_HZ    = 10_000_000;
    localparam int unsigned OSC_CLK_HZ    = 16_000_000;
    localparam int unsigned OVERSAMPLE    = 16;
    localparam logic [3:0]  TICK_LAST     = 4'(OVERSAMPLE - 1);
    localparam logic [3:0]  TICK_MID      = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [2:0]  MIN_BITS_LAST = 3'h4;
    localparam logic [1:0]  WLEN_RESET    = 2'h3;

    typedef enum logic [2:0] {
        parity_none_sel,
        parity_even_sel,
        parity_odd_sel,
        parity_one_sel,
        parity_zero_sel
    } ufc_parity_t;

    typedef struct packed {
        logic [1:0]  wlen;
        logic        two_stop;
        ufc_parity_t parity;
    } ufc_frame_cfg_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              parity_err;
        logic              frame_err;
    } ufc_rx_char_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PARITY,
        ST_STOP
    } ufc_state_t;

    function automatic logic [2:0] last_bit(input ufc_frame_cfg_t cfg);
        return MIN_BITS_LAST + 3'(cfg.wlen);
    endfunction : last_bit

    function automatic logic parity_bit(input logic [DATA_W-1:0] data,
                                        input ufc_frame_cfg_t    cfg);
        logic x;
        x = 1'b0;
        for (int i = 0; i < DATA_W; i++) begin
            if (3'(i) <= last_bit(cfg)) begin
                x = x ^ data[i];
            end
        end
        case (cfg.parity)
            parity_even_sel: return x;
            parity_odd_sel:  return ~x;
            parity_one_sel:  return 1'b1;
            default:         return 1'b0;
        endcase
    endfunction : parity_bit

endpackage : ufc_pkg

// >>> verilog/ufc_fifo.sv
`timescale 1ns/1ps
module ufc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic             pop_i,
    output logic      [WIDTH-1:0] head_o,
    output logic                  full_o,
    output logic                  empty_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("ufc_fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
    logic             do_push, do_pop;

    assign full_o  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty_o = (wr_q == rd_q);
    assign head_o  = mem_q[rd_q[AW-1:0]];
    assign do_push = push_i && !full_o && !flush_i;
    assign do_pop  = pop_i && !empty_o && !flush_i;

    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        if (flush_i) begin
            rd_d = wr_q;
        end
        if (do_push) begin
            mem_d[wr_q[AW-1:0]] = data_i;
            wr_d                = wr_q + 1'b1;
        end
        if (do_pop) begin
            rd_d = rd_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            mem_q <= mem_d;
        end
    end
endmodule : ufc_fifo

// >>> verilog/ufc_baud.sv
`timescale 1ns/1ps
module ufc_baud #(
    parameter int unsigned DIV_W = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ref_tick_i,
    input  wire logic [DIV_W-1:0] div_i,
    output logic                  tick16_o
);
    initial begin
        if (DIV_W < 1) begin
            $error("ufc_baud divisor width must be positive");
        end
    end

    logic [DIV_W-1:0] cnt_q, cnt_d;
    logic             tick_q, tick_d;

    // divisor zero parks the generator: the dc end of the range
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (div_i == '0) begin
            cnt_d = '0;
        end else if (ref_tick_i) begin
            if (cnt_q >= div_i - 1'b1) begin // R15
                cnt_d  = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick16_o = tick_q;
endmodule : ufc_baud

// >>> verilog/ufc_core.sv
`timescale 1ns/1ps
module ufc_core #(
    parameter int unsigned DIV_W    = ufc_pkg::DIV_W,
    parameter int unsigned TX_DEPTH = ufc_pkg::TX_DEPTH,
    parameter int unsigned RX_DEPTH = ufc_pkg::RX_DEPTH
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    enable_i,
    input  wire ufc_pkg::ufc_frame_cfg_t cfg_i,
    input  wire logic [DIV_W-1:0]        baud_div_i,
    output logic      [DIV_W-1:0]        baud_div_o,
    input  wire logic                    baud_ref_internal_osc_i,
    input  wire logic                    precision_internal_osc_tick_i,
    input  wire logic                    break_request_i,
    input  wire logic                    infrared_mode_i,
    output logic                         infrared_mode_o,
    input  wire logic                    tx_write_i,
    input  wire logic [7:0]              tx_data_i,
    output logic                         tx_full_o,
    output logic                         busy_o,
    input  wire logic                    rx_read_i,
    output ufc_pkg::ufc_rx_char_t        rx_char_o,
    output logic                         rx_avail_o,
    output logic                         rx_overrun_o,
    input  wire logic                    rxd_i,
    output logic                         txd_o
);
    initial begin
        if (DIV_W < 4 || TX_DEPTH < 2 || RX_DEPTH < 2) begin
            $error("ufc_core parameters out of range");
        end
    end

    // baud reference and oversampling tick
    logic ref_tick;
    logic tick;

    assign ref_tick = baud_ref_internal_osc_i ? precision_internal_osc_tick_i : 1'b1; // R6

    ufc_baud #(
        .DIV_W (DIV_W)
    ) u_baud (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ref_tick_i (ref_tick),
        .div_i      (baud_div_i),
        .tick16_o   (tick)
    );

    // fifos
    logic                  tx_empty, tx_pop, tx_flush;
    logic [7:0]            tx_head;
    logic                  rx_empty, rx_full, rx_push;
    ufc_pkg::ufc_rx_char_t rx_head, rx_word;

    ufc_fifo #(
        .WIDTH (ufc_pkg::DATA_W),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .flush_i (tx_flush),
        .push_i  (tx_write_i), // R5
        .data_i  (tx_data_i),
        .pop_i   (tx_pop),
        .head_o  (tx_head),
        .full_o  (tx_full_o), // R5
        .empty_o (tx_empty)
    );

    ufc_fifo #(
        .WIDTH ($bits(ufc_pkg::ufc_rx_char_t)),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .flush_i (1'b0),
        .push_i  (rx_push),
        .data_i  (rx_word),
        .pop_i   (rx_read_i), // R4
        .head_o  (rx_head),
        .full_o  (rx_full),
        .empty_o (rx_empty)
    );

    // transmitter
    ufc_pkg::ufc_state_t tx_st_q, tx_st_d;
    logic [3:0]          tx_cnt_q, tx_cnt_d;
    logic [2:0]          tx_bit_q, tx_bit_d;
    logic                tx_stop_q, tx_stop_d;
    logic [7:0]          tx_sh_q, tx_sh_d;
    logic                tx_par_q, tx_par_d;
    logic                txd_q, txd_d;
    logic                tx_bit_end;

    assign tx_bit_end = tick && (tx_cnt_q == ufc_pkg::TICK_LAST);
    // the current character is never cut short; the queue goes once idle
    assign tx_flush   = !enable_i && (tx_st_q == ufc_pkg::ST_IDLE); // R12

    always_comb begin
        tx_st_d   = tx_st_q;
        tx_cnt_d  = tx_cnt_q;
        tx_bit_d  = tx_bit_q;
        tx_stop_d = tx_stop_q;
        tx_sh_d   = tx_sh_q;
        tx_par_d  = tx_par_q;
        tx_pop    = 1'b0;
        if (tx_st_q != ufc_pkg::ST_IDLE && tick) begin
            tx_cnt_d = tx_cnt_q + 4'h1;
        end
        case (tx_st_q)
            ufc_pkg::ST_IDLE: begin
                if (enable_i && !tx_empty) begin // R12
                    tx_pop   = 1'b1;
                    tx_sh_d  = tx_head;
                    tx_par_d = ufc_pkg::parity_bit(tx_head, cfg_i); // R11
                    tx_cnt_d = '0;
                    tx_st_d  = ufc_pkg::ST_START; // R17
                end
            end
            ufc_pkg::ST_START: begin
                if (tx_bit_end) begin
                    tx_bit_d = '0;
                    tx_st_d  = ufc_pkg::ST_DATA;
                end
            end
            ufc_pkg::ST_DATA: begin
                if (tx_bit_end) begin
                    tx_sh_d  = {1'b0, tx_sh_q[7:1]}; // R17
                    tx_bit_d = tx_bit_q + 3'h1;
                    if (tx_bit_q == ufc_pkg::last_bit(cfg_i)) begin // R14
                        tx_stop_d = 1'b0;
                        tx_st_d   = (cfg_i.parity == ufc_pkg::parity_none_sel) ?
                                    ufc_pkg::ST_STOP : ufc_pkg::ST_PARITY; // R9
                    end
                end
            end
            ufc_pkg::ST_PARITY: begin
                if (tx_bit_end) begin
                    tx_st_d = ufc_pkg::ST_STOP;
                end
            end
            ufc_pkg::ST_STOP: begin
                if (tx_bit_end) begin
                    if (tx_stop_q == cfg_i.two_stop) begin // R10
                        tx_st_d = ufc_pkg::ST_IDLE;
                    end else begin
                        tx_stop_d = 1'b1;
                    end
                end
            end
            default: tx_st_d = ufc_pkg::ST_IDLE;
        endcase
        case (tx_st_q)
            ufc_pkg::ST_START:  txd_d = 1'b0;
            ufc_pkg::ST_DATA:   txd_d = tx_sh_q[0];
            ufc_pkg::ST_PARITY: txd_d = tx_par_q;
            default:            txd_d = 1'b1; // R17
        endcase
        // break overrides framing but the frame itself keeps running
        if (break_request_i) begin
            txd_d = 1'b0; // R1
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st_q   <= ufc_pkg::ST_IDLE;
            tx_cnt_q  <= '0;
            tx_bit_q  <= '0;
            tx_stop_q <= 1'b0;
            tx_sh_q   <= '0;
            tx_par_q  <= 1'b0;
            txd_q     <= 1'b1;
        end else begin
            tx_st_q   <= tx_st_d;
            tx_cnt_q  <= tx_cnt_d;
            tx_bit_q  <= tx_bit_d;
            tx_stop_q <= tx_stop_d;
            tx_sh_q   <= tx_sh_d;
            tx_par_q  <= tx_par_d;
            txd_q     <= txd_d;
        end
    end

    assign txd_o  = txd_q;
    assign busy_o = !tx_empty || (tx_st_q != ufc_pkg::ST_IDLE); // R2

    // receiver
    ufc_pkg::ufc_state_t rx_st_q, rx_st_d;
    logic [3:0]          rx_cnt_q, rx_cnt_d;
    logic [2:0]          rx_bit_q, rx_bit_d;
    logic                rx_stop_q, rx_stop_d;
    logic [7:0]          rx_sh_q, rx_sh_d;
    logic                rx_pe_q, rx_pe_d;
    logic                rx_fe_q, rx_fe_d;
    logic                rx_centre;
    logic [7:0]          rx_aligned;

    assign rx_centre  = tick && (rx_cnt_q == ufc_pkg::TICK_LAST); // R16
    // shifted in from the top, so short characters need right alignment
    assign rx_aligned = rx_sh_q >> (3'h7 - ufc_pkg::last_bit(cfg_i));

    always_comb begin
        rx_st_d   = rx_st_q;
        rx_cnt_d  = rx_cnt_q;
        rx_bit_d  = rx_bit_q;
        rx_stop_d = rx_stop_q;
        rx_sh_d   = rx_sh_q;
        rx_pe_d   = rx_pe_q;
        rx_fe_d   = rx_fe_q;
        rx_push   = 1'b0;
        rx_word   = '{data: rx_aligned, parity_err: rx_pe_q, frame_err: rx_fe_q};
        if (rx_st_q != ufc_pkg::ST_IDLE && tick) begin
            rx_cnt_d = rx_cnt_q + 4'h1;
        end
        case (rx_st_q)
            ufc_pkg::ST_IDLE: begin
                if (enable_i && tick && !rxd_i) begin
                    rx_cnt_d = '0;
                    rx_pe_d  = 1'b0;
                    rx_fe_d  = 1'b0;
                    rx_st_d  = ufc_pkg::ST_START;
                end
            end
            ufc_pkg::ST_START: begin
                if (tick && rx_cnt_q == ufc_pkg::TICK_MID) begin // R16
                    // a glitch shorter than half a bit is not a start bit
                    rx_cnt_d = '0;
                    rx_bit_d = '0;
                    rx_st_d  = rxd_i ? ufc_pkg::ST_IDLE : ufc_pkg::ST_DATA;
                end
            end
            ufc_pkg::ST_DATA: begin
                if (rx_centre) begin
                    rx_sh_d  = {rxd_i, rx_sh_q[7:1]}; // R17
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == ufc_pkg::last_bit(cfg_i)) begin // R14
                        rx_stop_d = 1'b0;
                        rx_st_d   = (cfg_i.parity == ufc_pkg::parity_none_sel) ?
                                    ufc_pkg::ST_STOP : ufc_pkg::ST_PARITY; // R9
                    end
                end
            end
            ufc_pkg::ST_PARITY: begin
                if (rx_centre) begin
                    rx_pe_d = rxd_i != ufc_pkg::parity_bit(rx_aligned, cfg_i); // R11
                    rx_st_d = ufc_pkg::ST_STOP;
                end
            end
            ufc_pkg::ST_STOP: begin
                if (rx_centre) begin
                    rx_fe_d       = rx_fe_q || !rxd_i;
                    rx_word.frame_err = rx_fe_q || !rxd_i;
                    if (rx_stop_q == cfg_i.two_stop) begin // R10
                        rx_push = !rx_full;
                        rx_st_d = ufc_pkg::ST_IDLE;
                    end else begin
                        rx_stop_d = 1'b1;
                    end
                end
            end
            default: rx_st_d = ufc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st_q   <= ufc_pkg::ST_IDLE;
            rx_cnt_q  <= '0;
            rx_bit_q  <= '0;
            rx_stop_q <= 1'b0;
            rx_sh_q   <= '0;
            rx_pe_q   <= 1'b0;
            rx_fe_q   <= 1'b0;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_cnt_q  <= rx_cnt_d;
            rx_bit_q  <= rx_bit_d;
            rx_stop_q <= rx_stop_d;
            rx_sh_q   <= rx_sh_d;
            rx_pe_q   <= rx_pe_d;
            rx_fe_q   <= rx_fe_d;
        end
    end

    // software side registers
    ufc_pkg::ufc_rx_char_t rx_char_q, rx_char_d;
    logic                  ovr_q, ovr_d;
    logic                  ir_q, ir_d;
    logic [DIV_W-1:0]      div_q, div_d;

    always_comb begin
        rx_char_d = rx_char_q;
        if (rx_read_i && !rx_empty) begin
            rx_char_d = rx_head; // R4
        end
        ovr_d = (rx_st_q == ufc_pkg::ST_STOP) && rx_centre &&
                (rx_stop_q == cfg_i.two_stop) && rx_full;
        // mode only follows software while the unit is off
        ir_d  = enable_i ? ir_q : infrared_mode_i; // R13
        div_d = baud_div_i; // R8
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_char_q <= '0;
            ovr_q     <= 1'b0;
            ir_q      <= 1'b0;
            div_q     <= '0;
        end else begin
            rx_char_q <= rx_char_d;
            ovr_q     <= ovr_d;
            ir_q      <= ir_d;
            div_q     <= div_d;
        end
    end

    assign rx_char_o       = rx_char_q;
    assign rx_avail_o      = !rx_empty; // R3
    assign rx_overrun_o    = ovr_q;
    assign infrared_mode_o = ir_q;
    assign baud_div_o      = div_q; // R8
endmodule : ufc_core

// >>> verif/ufc_core_checker.sv
`timescale 1ns/1ps
module ufc_core_checker #(
    parameter int unsigned DIV_W = 16
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  enable_i,
    input wire logic [DIV_W-1:0]      baud_div_i,
    input wire logic [DIV_W-1:0]      baud_div_o,
    input wire logic                  break_request_i,
    input wire logic                  infrared_mode_i,
    input wire logic                  infrared_mode_o,
    input wire logic                  tx_write_i,
    input wire logic                  tx_full_o,
    input wire logic                  busy_o,
    input wire logic                  rx_read_i,
    input wire ufc_pkg::ufc_rx_char_t rx_char_o,
    input wire logic                  rx_avail_o,
    input wire logic                  txd_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a write counts only once enable has settled, so a pending flush cannot eat it
    sequence s_write;
        tx_write_i && !tx_full_o && enable_i && $past(enable_i);
    endsequence
    sequence s_idle_write;
        s_write ##0 (!busy_o && !break_request_i);
    endsequence
    chk_break_low: assert property (break_request_i |=> !txd_o)
        else $error("line not low during break");
    chk_idle_high: assert property (!busy_o && !break_request_i |=> txd_o)
        else $error("idle line not high");
    chk_low_busy: assert property (!txd_o && !$past(break_request_i) |-> busy_o)
        else $error("busy low while a frame is on the line");
    chk_write_busy: assert property (s_write |=> busy_o)
        else $error("accepted write did not raise busy");
    chk_start_bit: assert property (s_idle_write |-> ##3 !txd_o)
        else $error("no start bit after write");
    chk_read_only: assert property (!(rx_read_i && rx_avail_o) |=> $stable(rx_char_o))
        else $error("receive data changed without a pop");
    chk_avail_fall: assert property ($fell(rx_avail_o) |-> $past(rx_read_i))
        else $error("receive flag fell without a read");
    chk_div_copy: assert property (!$past(rst_i) |-> baud_div_o == $past(baud_div_i))
        else $error("divisor readback wrong");
    chk_ir_hold: assert property (enable_i |=> $stable(infrared_mode_o))
        else $error("infrared mode changed while enabled");
    chk_ir_follow: assert property (!enable_i |=> infrared_mode_o == $past(infrared_mode_i))
        else $error("infrared mode not taken while disabled");
endmodule : ufc_core_checker

// >>> verif/ufc_peer.sv
`timescale 1ns/1ps
module ufc_peer (
    input  wire logic                    clk_i,
    input  wire logic                    txd_i,
    input  wire ufc_pkg::ufc_frame_cfg_t cfg_i,
    input  var int                       bit_cyc_i,
    output logic                         rxd_o
);
    logic [9:0] got_q[$];
    logic [7:0] rd;
    logic       rp;
    logic       rs;
    function automatic logic par_of(input logic [7:0] d, input ufc_pkg::ufc_frame_cfg_t c);
        logic x;
        x = ^(d & (8'hff >> (3 - c.wlen)));
        case (c.parity)
            ufc_pkg::parity_even_sel: return x;
            ufc_pkg::parity_odd_sel:  return !x;
            ufc_pkg::parity_one_sel:  return 1'b1;
            default:                  return 1'b0;
        endcase
    endfunction : par_of
    task automatic hold(input int n);
        repeat (n) @(negedge clk_i);
    endtask : hold
    task automatic bit_out(input logic b);
        rxd_o = b;
        hold(bit_cyc_i);
    endtask : bit_out
    // call at a falling edge; line goes back to mark level after the frame
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        bit_out(1'b0);
        for (int i = 0; i < 5 + cfg_i.wlen; i++) bit_out(d[i]);
        if (cfg_i.parity != ufc_pkg::parity_none_sel) bit_out(par_of(d, cfg_i) ^ bad_par);
        bit_out(!bad_stop);
        if (cfg_i.two_stop) bit_out(1'b1);
        rxd_o = 1'b1;
    endtask : send
    // centre sampling tolerates a start bit up to one tick short
    initial begin
        rxd_o = 1'b1;
        forever begin
            @(negedge txd_i);
            hold(bit_cyc_i / 2);
            rd = 8'h00;
            rp = 1'b0;
            for (int i = 0; i < 5 + cfg_i.wlen; i++) begin
                hold(bit_cyc_i);
                rd[i] = txd_i;
            end
            if (cfg_i.parity != ufc_pkg::parity_none_sel) begin
                hold(bit_cyc_i);
                rp = txd_i;
            end
            hold(bit_cyc_i);
            rs = txd_i;
            if (cfg_i.two_stop) begin
                hold(bit_cyc_i);
                rs = rs & txd_i;
            end
            got_q.push_back({rd, rp, rs});
            wait (txd_i === 1'b1);
        end
    end
endmodule : ufc_peer

// >>> verif/ufc_core_tb.sv
`timescale 1ns/1ps
module ufc_core_tb;
    logic clk_i, rst_i, enable_i, osc_sel, osc_tick, break_request_i, ir_i, ir_o;
    logic tx_write_i, tx_full_o, busy_o, rx_read_i, rx_avail_o, ovr, rxd, txd_o;
    logic [15:0] baud_div_i, baud_div_o;
    logic [7:0] tx_data_i, d;
    logic [9:0] g;
    ufc_pkg::ufc_frame_cfg_t cfg_i;
    ufc_pkg::ufc_rx_char_t   rx_char_o;
    int n_fail, total_checks, bit_cyc, n_ovr;
    ufc_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i), .cfg_i(cfg_i),
        .baud_div_i(baud_div_i), .baud_div_o(baud_div_o), .baud_ref_internal_osc_i(osc_sel),
        .precision_internal_osc_tick_i(osc_tick), .break_request_i(break_request_i),
        .infrared_mode_i(ir_i), .infrared_mode_o(ir_o), .tx_write_i(tx_write_i),
        .tx_data_i(tx_data_i), .tx_full_o(tx_full_o), .busy_o(busy_o), .rx_read_i(rx_read_i),
        .rx_char_o(rx_char_o), .rx_avail_o(rx_avail_o), .rx_overrun_o(ovr), .rxd_i(rxd),
        .txd_o(txd_o));
    ufc_peer u_peer (.clk_i(clk_i), .txd_i(txd_o), .cfg_i(cfg_i), .bit_cyc_i(bit_cyc),
        .rxd_o(rxd));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // reference pulse every other cycle, so the oscillator rate differs from the clock
    always @(negedge clk_i) osc_tick <= rst_i ? 1'b0 : !osc_tick;
    always @(negedge clk_i) n_ovr += 32'(ovr);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic put(input logic [7:0] v);
        for (int k = 0; k < 5000 && tx_full_o !== 1'b0; k++) @(negedge clk_i);
        tx_data_i = v;
        tx_write_i = 1'b1;
        @(negedge clk_i);
        tx_write_i = 1'b0;
        @(negedge clk_i);
    endtask : put
    task automatic get(input logic [9:0] exp);
        for (int k = 0; k < 5000 && rx_avail_o !== 1'b1; k++) @(negedge clk_i);
        rx_read_i = 1'b1;
        @(negedge clk_i);
        rx_read_i = 1'b0;
        check("rx char", 16'(rx_char_o), 16'(exp));
        @(negedge clk_i);
    endtask : get
    task automatic wait_idle;
        for (int k = 0; k < 20000 && busy_o !== 1'b0; k++) @(negedge clk_i);
        check("busy", 16'(busy_o), 16'h0000);
        repeat (bit_cyc) @(negedge clk_i);
    endtask : wait_idle
    task automatic loop_back(input logic [7:0] v);
        d = v & (8'hff >> (3 - cfg_i.wlen));
        put(v);
        wait_idle();
        g = u_peer.got_q.pop_front();
        check("tx data", 16'(g[9:2]), 16'(d));
        if (cfg_i.parity != ufc_pkg::parity_none_sel)
            check("tx parity", 16'(g[1]), 16'(u_peer.par_of(v, cfg_i)));
        check("tx stop", 16'(g[0]), 16'h0001);
        u_peer.send(d, 1'b0, 1'b0);
        get({d, 2'b00});
    endtask : loop_back
    initial begin
        rst_i = 1'b1; enable_i = 1'b0; osc_sel = 1'b0; osc_tick = 1'b0; ir_i = 1'b0;
        break_request_i = 1'b0; tx_write_i = 1'b0; rx_read_i = 1'b0; tx_data_i = 8'h00;
        cfg_i = '{wlen: 2'h3, two_stop: 1'b0, parity: ufc_pkg::parity_none_sel};
        baud_div_i = 16'h0001; n_fail = 0; total_checks = 0; bit_cyc = 16;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        enable_i = 1'b1;
        for (int p = 0; p < 5; p++) begin
            cfg_i = '{wlen: 2'(p), two_stop: p[0], parity: ufc_pkg::ufc_parity_t'(p)};
            loop_back(8'(8'h9c + p * 37));
        end
        u_peer.send(8'h15, 1'b1, 1'b0);
        get({8'h15, 2'b10});
        u_peer.send(8'h0a, 1'b0, 1'b1);
        get({8'h0a, 2'b01});
        $display("test formats done");
        cfg_i = '{wlen: 2'h3, two_stop: 1'b1, parity: ufc_pkg::parity_none_sel};
        for (int i = 0; i < 17; i++) u_peer.send(8'(8'h30 + i), 1'b0, 1'b0);
        check("overrun", 16'(n_ovr), 16'h0001);
        for (int i = 0; i < 16; i++) get({8'(8'h30 + i), 2'b00});
        check("rx avail", 16'(rx_avail_o), 16'h0000);
        rx_read_i = 1'b1;
        @(negedge clk_i);
        rx_read_i = 1'b0;
        check("empty read", 16'(rx_char_o), {6'h00, 8'h3f, 2'b00});
        $display("test receive fifo done");
        baud_div_i = 16'h0000;
        for (int i = 0; i < 17; i++) put(8'(i));
        check("tx full", 16'(tx_full_o), 16'h0001);
        enable_i = 1'b0;
        baud_div_i = 16'h0001;
        wait_idle();
        check("sent on disable", 16'(u_peer.got_q.size()), 16'h0001);
        check("tx full", 16'(tx_full_o), 16'h0000);
        u_peer.got_q.delete();
        enable_i = 1'b1;
        $display("test fill and disable done");
        break_request_i = 1'b1;
        repeat (2 * 12 * 16) @(negedge clk_i);
        check("break line", 16'(txd_o), 16'h0000);
        break_request_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("line after break", 16'(txd_o), 16'h0001);
        repeat (300) @(negedge clk_i);
        u_peer.got_q.delete();
        $display("test break done");
        osc_sel = 1'b1;
        bit_cyc = 32;
        loop_back(8'hc3);
        baud_div_i = 16'h0002;
        @(negedge clk_i);
        check("divisor", baud_div_o, 16'h0002);
        bit_cyc = 64;
        loop_back(8'h5e);
        $display("test baud reference done");
        ir_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("ir while enabled", 16'(ir_o), 16'h0000);
        enable_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("ir while disabled", 16'(ir_o), 16'h0001);
        $display("test infrared done");
        report_and_stop();
    end
    // the full run needs about 8000 cycles
    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        report_and_stop();
    end
endmodule : ufc_core_tb
bind ufc_core ufc_core_checker #(.DIV_W(DIV_W)) u_chk (.clk_i, .rst_i, .enable_i, .baud_div_i,
    .baud_div_o, .break_request_i, .infrared_mode_i, .infrared_mode_o, .tx_write_i, .tx_full_o,
    .busy_o, .rx_read_i, .rx_char_o, .rx_avail_o, .txd_o);
